// file: pkg/c2d_pkg.sv
// Constants and carrier types for the boot-default copy of configuration register 2.
// Assumes a command decoder on the same clock that delivers one decoded command per pulse.
package c2d_pkg;
    // Command opcodes as seen by the decoder.
    localparam logic [7:0] READ_ANY_REG_CMD = 8'h65;
    localparam logic [7:0] WRITE_ANY_REG_CMD = 8'h71;
    localparam logic [7:0] NONVOL_WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] WRITE_REGS_CMD = 8'h01;
    // Register address of the boot copy in the any-register space.
    localparam logic [23:0] CFG2_BOOT_ADDR = 24'h000003;
    // Field positions.
    localparam int IO_RST_BIT = 7;
    localparam int DRIVE_HI = 6;
    localparam int DRIVE_LO = 5;
    localparam int WIDE_INSTR_BIT = 3;
    localparam int PROTECT_BIT = 2;
    localparam int ADDR_LEN_BIT = 1;
    localparam int BUSY_BIT = 0;
    // Reset value and the mask of writable bits (4 and 0 are reserved).
    localparam logic [7:0] CFG2_BOOT_RESET = 8'h60;
    localparam logic [7:0] CFG2_BOOT_WMASK = 8'hee;
    // Programming time of the non-volatile cells.
    localparam int CLK_PERIOD_NS = 20;
    localparam int PROG_TIME_NS = 200;
    localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] PROG_CYCLES_W = 8'(PROG_CYCLES);

    typedef struct packed {
        logic valid;
        logic [7:0] opcode;
        logic [23:0] addr;
        logic [7:0] data;
    } c2d_cmd_t;

    typedef struct packed {
        logic io_pin_reset_enable_default;
        logic [1:0] drive_strength_default;
        logic wide_instruction_default;
        logic protect_scheme_default;
        logic addr_len_default;
    } c2d_defaults_t;

    typedef enum logic [1:0] {
        C2D_LOAD = 2'b00,
        C2D_IDLE = 2'b01,
        C2D_PROG = 2'b11
    } c2d_state_t;
endpackage : c2d_pkg

// file: rtl/c2d_boot_copy.sv
// Boot-default copy of configuration register 2 with its command handling and reset reload.
// Assumes reset_n_i is the power-on reset and that warm resets arrive as one-cycle pulses.
//
// Contract
// - Any-register commands read and write this register.
// - Boot copy only seeds live control state.
// - Write needs prior non-volatile write enable.
// - Bit 7 defaults 0, enables pin reset.
// - Bits 6:5 default 11, select drive strength.
// - Bit 3 defaults 0, selects wide instructions.
// - Bit 2 defaults 0, selects protection scheme.
// - Bit 1 defaults 0, selects address length.
// - Bits 4 and 0 reserved, default 0.
// - Quad bit governs when pin resets.
`timescale 1ns/1ps
module c2d_boot_copy
    import c2d_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic hw_reset_i,
    input wire logic sw_reset_i,
    input wire c2d_cmd_t cmd_i,
    input wire logic chip_select_n_i,
    input wire logic live_io_reset_enable_i,
    input wire logic live_wide_instruction_i,
    input wire logic cfg1_live_quad_i,
    output logic cmd_ready_o,
    output logic rd_valid_o,
    output logic [7:0] rd_data_o,
    output logic busy_o,
    output logic load_o,
    output c2d_defaults_t defaults_o,
    output logic data_line_three_reset_o
);
    logic [7:0] cfg2_boot_copy_reg, cfg2_boot_copy_next;
    c2d_state_t state_reg, state_next;
    logic wel_reg, wel_next;
    logic [7:0] prog_cnt_reg, prog_cnt_next;
    logic [7:0] prog_data_reg, prog_data_next;
    logic rd_valid_reg, rd_valid_next;
    logic [7:0] rd_data_reg, rd_data_next;
    logic load_reg, load_next;
    logic [2:0] cs_sync_reg, cs_sync_next;
    logic cs_high_reg, cs_high_next;
    logic rd_hit, wr_hit, nonvol_write_enable_cmd_hit;

    always_comb
    begin
        rd_hit = cmd_i.valid && cmd_i.opcode == READ_ANY_REG_CMD && cmd_i.addr == CFG2_BOOT_ADDR;
        wr_hit = cmd_i.valid && ((cmd_i.opcode == WRITE_ANY_REG_CMD && cmd_i.addr == CFG2_BOOT_ADDR)
                 || cmd_i.opcode == WRITE_REGS_CMD);
        nonvol_write_enable_cmd_hit = cmd_i.valid && cmd_i.opcode == NONVOL_WRITE_ENABLE_CMD;
    end

    // The copy is kept across warm resets; only power-on reloads its reset value, like real cells would.
    always_comb
    begin
        state_next = state_reg;
        cfg2_boot_copy_next = cfg2_boot_copy_reg;
        wel_next = wel_reg;
        prog_cnt_next = prog_cnt_reg;
        prog_data_next = prog_data_reg;
        rd_valid_next = 1'b0;
        rd_data_next = rd_data_reg;
        load_next = 1'b0;
        case (state_reg)
            C2D_LOAD:
            begin
                load_next = 1'b1;
                state_next = C2D_IDLE;
            end
            C2D_IDLE:
            begin
                if (rd_hit)
                begin
                    rd_valid_next = 1'b1;
                    rd_data_next = cfg2_boot_copy_reg & CFG2_BOOT_WMASK;
                end
                if (nonvol_write_enable_cmd_hit)
                begin
                    wel_next = 1'b1;
                end
                else if (wr_hit && wel_reg)
                begin
                    wel_next = 1'b0;
                    prog_data_next = cmd_i.data & CFG2_BOOT_WMASK;
                    prog_cnt_next = PROG_CYCLES_W;
                    state_next = C2D_PROG;
                end
                else if (wr_hit)
                begin
                    wel_next = 1'b0;
                end
            end
            C2D_PROG:
            begin
                // Reads stay legal while programming; the old value is returned.
                if (rd_hit)
                begin
                    rd_valid_next = 1'b1;
                    rd_data_next = cfg2_boot_copy_reg & CFG2_BOOT_WMASK;
                end
                prog_cnt_next = prog_cnt_reg - 8'h01;
                if (prog_cnt_reg == 8'h01)
                begin
                    cfg2_boot_copy_next = prog_data_reg;
                    state_next = C2D_IDLE;
                end
            end
            default:
            begin
                state_next = C2D_LOAD;
            end
        endcase
        // A warm reset abandons programming short of its last cycle, where the write still lands, and reloads the live copy.
        if (hw_reset_i || sw_reset_i)
        begin
            state_next = C2D_LOAD;
            wel_next = 1'b0;
            rd_valid_next = 1'b0;
        end
    end

    always_comb
    begin
        cs_sync_next = {cs_sync_reg[1:0], chip_select_n_i};
        cs_high_next = cs_high_reg;
        if (cs_sync_reg[1] == cs_sync_reg[2])
        begin
            cs_high_next = cs_sync_reg[2];
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_reg <= C2D_LOAD;
            cfg2_boot_copy_reg <= CFG2_BOOT_RESET;
            wel_reg <= 1'b0;
            prog_cnt_reg <= 8'h00;
            prog_data_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
            rd_data_reg <= 8'h00;
            load_reg <= 1'b0;
            cs_sync_reg <= 3'h7;
            cs_high_reg <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            cfg2_boot_copy_reg <= cfg2_boot_copy_next;
            wel_reg <= wel_next;
            prog_cnt_reg <= prog_cnt_next;
            prog_data_reg <= prog_data_next;
            rd_valid_reg <= rd_valid_next;
            rd_data_reg <= rd_data_next;
            load_reg <= load_next;
            cs_sync_reg <= cs_sync_next;
            cs_high_reg <= cs_high_next;
        end
    end

    assign cmd_ready_o = state_reg != C2D_LOAD;
    assign rd_valid_o = rd_valid_reg;
    assign rd_data_o = rd_data_reg;
    assign busy_o = state_reg == C2D_PROG;
    assign load_o = load_reg;
    assign defaults_o.io_pin_reset_enable_default = cfg2_boot_copy_reg[IO_RST_BIT];
    assign defaults_o.drive_strength_default = cfg2_boot_copy_reg[DRIVE_HI:DRIVE_LO];
    assign defaults_o.wide_instruction_default = cfg2_boot_copy_reg[WIDE_INSTR_BIT];
    assign defaults_o.protect_scheme_default = cfg2_boot_copy_reg[PROTECT_BIT];
    assign defaults_o.addr_len_default = cfg2_boot_copy_reg[ADDR_LEN_BIT];
    // The live copy, not the boot copy, decides whether the pin acts as reset.
    assign data_line_three_reset_o = live_io_reset_enable_i
        && (cs_high_reg || !cfg1_live_quad_i || !live_wide_instruction_i);

    logic prog_start;
    assign prog_start = state_reg == C2D_IDLE && wr_hit && wel_reg && !hw_reset_i && !sw_reset_i;

    reset_value_a: assert property (@(posedge clk_i) $rose(reset_n_i) |-> cfg2_boot_copy_reg == CFG2_BOOT_RESET)
        else $error("boot copy reset value wrong");
    reserved_read_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        rd_valid_o |-> (rd_data_o[4] == 1'b0 && rd_data_o[0] == 1'b0))
        else $error("reserved bit read nonzero");
    reserved_store_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        cfg2_boot_copy_reg[4] == 1'b0 && cfg2_boot_copy_reg[0] == 1'b0)
        else $error("reserved bit stored");
    read_answer_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (rd_hit && state_reg != C2D_LOAD && !hw_reset_i && !sw_reset_i) |=> rd_valid_o
        && rd_data_o == ($past(cfg2_boot_copy_reg) & CFG2_BOOT_WMASK))
        else $error("read answer missing or wrong");
    write_gated_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (wr_hit && !wel_reg && state_reg == C2D_IDLE) |=> !busy_o)
        else $error("write accepted without enable");
    prog_busy_a: assert property (@(posedge clk_i) disable iff (!reset_n_i || hw_reset_i || sw_reset_i)
        prog_start |=> busy_o [*8])
        else $error("busy dropped early");
    prog_done_a: assert property (@(posedge clk_i) disable iff (!reset_n_i || hw_reset_i || sw_reset_i)
        prog_start |-> ##11 (!busy_o && cfg2_boot_copy_reg == (CFG2_BOOT_WMASK & $past(cmd_i.data, 11))))
        else $error("programming did not finish with data");
    reload_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (hw_reset_i || sw_reset_i) |=> !cmd_ready_o ##1 (load_o && cmd_ready_o))
        else $error("reload before commands missing");
    pin_reset_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (!live_io_reset_enable_i) |-> !data_line_three_reset_o)
        else $error("pin reset without enable");
    cover_read_c: cover property (@(posedge clk_i) disable iff (!reset_n_i) rd_valid_o);
    cover_prog_c: cover property (@(posedge clk_i) disable iff (!reset_n_i) $fell(busy_o));
    cover_warm_c: cover property (@(posedge clk_i) disable iff (!reset_n_i) busy_o && sw_reset_i);
    // Only the last cycle of a programming run may change the stored byte; warm resets leave it alone.
    copy_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (state_reg != C2D_PROG) |=> $stable(cfg2_boot_copy_reg))
        else $error("boot copy changed outside programming");
    enable_once_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (state_reg == C2D_IDLE && wr_hit) |=> !wel_reg)
        else $error("write enable not consumed by write");
    cover_load_c: cover property (@(posedge clk_i) disable iff (!reset_n_i)
        load_o && defaults_o.io_pin_reset_enable_default);
endmodule : c2d_boot_copy

// file: testbench/c2d_host_model.sv
// Host-side model: issues decoded register commands and polls the busy flag.
// Assumes the command port is sampled on the rising edge of clk_i.
`timescale 1ns/1ps
module c2d_host_model
    import c2d_pkg::*;
(
    input wire logic clk_i,
    input wire logic busy_i,
    output c2d_cmd_t cmd_o
);
    initial cmd_o = '0;

    // Fields change at the falling edge and stand across one rising edge.
    task automatic issue(input logic [7:0] op, input logic [23:0] addr, input logic [7:0] data);
        @(negedge clk_i);
        cmd_o = '{valid: 1'b1, opcode: op, addr: addr, data: data};
        @(negedge clk_i);
        cmd_o.valid = 1'b0;
        // Released data shows the inverse so a stale byte is never mistaken for a live one.
        cmd_o.data = ~data;
    endtask : issue

    // Counts busy cycles until programming ends, giving up after 40 cycles.
    task automatic poll_busy(output logic [7:0] count);
        int n;
        count = 8'h00;
        for (n = 0; n < 40; n++)
        begin
            if (busy_i === 1'b1)
                count++;
            else if (count != 8'h00)
                break;
            @(negedge clk_i);
        end
    endtask : poll_busy
endmodule : c2d_host_model

// file: testbench/cfg2_nonvolatile_defaults_tb.sv
// Self-checking bench for the boot-default copy of configuration register 2.
// Assumes the host model drives commands; the bench drives resets and live pins.
`timescale 1ns/1ps
module cfg2_nonvolatile_defaults_tb;
    import c2d_pkg::*;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic hw_reset = 1'b0;
    logic sw_reset = 1'b0;
    logic cs_n = 1'b1;
    logic live_io = 1'b0;
    logic live_wide = 1'b0;
    logic live_quad = 1'b0;
    logic cmd_ready, rd_valid, busy, load, line3_reset;
    logic [7:0] rd_data;
    logic [7:0] cnt;
    c2d_defaults_t defaults;
    c2d_cmd_t cmd;
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;
    int i;

    c2d_host_model host (.clk_i(clk_i), .busy_i(busy), .cmd_o(cmd));
    c2d_boot_copy dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .hw_reset_i(hw_reset), .sw_reset_i(sw_reset),
        .cmd_i(cmd), .chip_select_n_i(cs_n), .live_io_reset_enable_i(live_io),
        .live_wide_instruction_i(live_wide), .cfg1_live_quad_i(live_quad), .cmd_ready_o(cmd_ready),
        .rd_valid_o(rd_valid), .rd_data_o(rd_data), .busy_o(busy), .load_o(load), .defaults_o(defaults),
        .data_line_three_reset_o(line3_reset));

    initial forever #10 clk_i = ~clk_i;

    task automatic tally_and_finish();
        if (fail_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    // The run is under two hundred cycles; this ceiling only catches a hang.
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask : check_byte

    function automatic logic [7:0] exp_def(input logic [7:0] s);
        return {2'b00, s[7], s[6:5], s[3], s[2], s[1]};
    endfunction : exp_def

    task automatic read_back(input logic [7:0] exp);
        host.issue(READ_ANY_REG_CMD, CFG2_BOOT_ADDR, 8'h00);
        check_byte({7'h00, rd_valid}, 8'h01);
        check_byte(rd_data, exp);
        @(negedge clk_i);
        check_byte({7'h00, rd_valid}, 8'h00);
    endtask : read_back

    // Busy stands one cycle per count of the programming timer.
    task automatic program_byte(input logic [7:0] op, input logic [7:0] d);
        host.issue(NONVOL_WRITE_ENABLE_CMD, CFG2_BOOT_ADDR, 8'h00);
        host.issue(op, CFG2_BOOT_ADDR, d);
        host.poll_busy(cnt);
        check_byte(cnt, PROG_CYCLES_W);
        check_byte({2'b00, defaults}, exp_def(d & 8'hee));
        read_back(d & 8'hee);
    endtask : program_byte

    // A warm reset reloads the live copy but keeps the stored byte.
    task automatic warm_reset(input logic use_hw, input logic [7:0] kept);
        @(negedge clk_i);
        hw_reset = use_hw;
        sw_reset = !use_hw;
        @(negedge clk_i);
        hw_reset = 1'b0;
        sw_reset = 1'b0;
        check_byte({6'h00, cmd_ready, load}, 8'h00);
        @(negedge clk_i);
        check_byte({6'h00, cmd_ready, load}, 8'h03);
        read_back(kept);
    endtask : warm_reset

    initial
    begin
        repeat (10) @(negedge clk_i);
        reset_n_i = 1'b1;
        repeat (3) @(negedge clk_i);
        check_byte({2'b00, defaults}, exp_def(8'h60));
        read_back(8'h60);
        host.issue(WRITE_ANY_REG_CMD, CFG2_BOOT_ADDR, 8'h00);
        repeat (3) @(negedge clk_i);
        check_byte({7'h00, busy}, 8'h00);
        read_back(8'h60);
        program_byte(WRITE_ANY_REG_CMD, 8'hff);
        program_byte(WRITE_REGS_CMD, 8'h91);
        warm_reset(1'b1, 8'h80);
        warm_reset(1'b0, 8'h80);
        // A warm reset in mid-programming abandons the write and keeps the old byte.
        host.issue(NONVOL_WRITE_ENABLE_CMD, CFG2_BOOT_ADDR, 8'h00);
        host.issue(WRITE_ANY_REG_CMD, CFG2_BOOT_ADDR, 8'h00);
        check_byte({7'h00, busy}, 8'h01);
        warm_reset(1'b0, 8'h80);
        check_byte({7'h00, busy}, 8'h00);
        for (i = 0; i < 16; i++)
        begin
            {cs_n, live_quad, live_wide, live_io} = i[3:0];
            repeat (5) @(negedge clk_i);
            check_byte({7'h00, line3_reset}, {7'h00, live_io & (cs_n | !live_quad | !live_wide)});
        end
        reset_n_i = 1'b0;
        repeat (2) @(negedge clk_i);
        reset_n_i = 1'b1;
        repeat (3) @(negedge clk_i);
        read_back(8'h60);
        tally_and_finish();
    end
endmodule : cfg2_nonvolatile_defaults_tb
